/* File: logic/ascii_cmd_defines.svh */
// Constants for the ASCII command interpreter
`ifndef ASCII_CMD_DEFINES_SVH
`define ASCII_CMD_DEFINES_SVH
`define CH_HAT     8'h5E
`define CH_CR      8'h0D
`define CH_SP      8'h20
`define CH_TILDE   8'h7E
`define CH_0       8'h30
`define CH_9       8'h39
`define CMD_SEL    8'h41
`define CMD_CLRQ   8'h62
`define CMD_QEN    8'h63
`define CMD_CTR    8'h43
`define CMD_RST    8'h45
`define CMD_SCRL   8'h46
`define CMD_BLNK   8'h47
`define CMD_CUR    8'h48
`define CMD_NL     8'h49
`define CMD_WRAP   8'h4A
`define CMD_TRIG   8'h4B
`define CMD_VAR    8'h4D
`define CMD_DEL    8'h4E
`define CMD_PROG   8'h4F
`define CMD_SHOW   8'h50
`define CMD_ATTR   8'h51
`define CMD_EOT    8'h5A
`define LEN_BAD    3'h7
`define Q_ALL      17'h0_FFFF
`define MSG_MAX    8'hDF
`define ROWS       3'h4
`define COLS       6'h28
`define RATE_MAX   17'h0_0063
`define N_SETS     17'h0_0004
`define DEF_SCROLL 7'h0A
`define DEF_BLINK  7'h05
`define FIFO_W     8
`define FIFO_D     16
`endif

/* File: logic/ascii_cmd_pkg.sv */
// Types shared by the ASCII command interpreter
`default_nettype none
package ascii_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HAT  = 3'h1,
    ST_OPER = 3'h3,
    ST_TEXT = 3'h2,
    ST_ATTR = 3'h6
  } parse_st_t;
  typedef logic [16:0] num_t;
endpackage
`default_nettype wire

/* File: logic/ascii_display_command_parser.sv */
// Receive FIFO and ASCII command interpreter of the message display
// Summary of operation
// R01: Only the chosen host port, computer or controller, feeds the interpreter.
// R02: Circumflex starts commands and is never shown; only printable text and carriage return are processed.
// R03: A command runs only after all its operand characters arrived.
// R04: Every circumflex drops a partial command, except attributes inside text.
// R05: Until selected, the unit ignores everything except unit-select.
// R06: Command letters are case sensitive.
// R07: Host sends two-digit group then four-digit unit, zero padded.
// R08: Every unit evaluates each unit-select; unmatched units become deselected.
// R09: Exact match, group with unit 0, or group 0 unit 0 selects.
// R10: Clear-queue removes one message; 65535 empties the queue; no reply.
// R11: Queue-enable: 0 enables, 1 disables; disabled after reset.
// R12: Center-mode: 0 off, 1 on.
// R13: Reset-display clears; 0 homes, 1 restores parameters, 2 keeps cursor.
// R14: Scroll rate 01..99 tenths sets the scroll step interval.
// R15: Blink rate sets on and off intervals, each 01..99 tenths.
// R16: Cursor command moves cursor to row 1..4, column 1..40.
// R17: Carriage return goes to next line start with new-line on, else this line.
// R18: Wrap on moves past line end to next line; off stays at end.
// R19: Trigger shows stored message by five-digit number; none shows nothing.
// R20: Variable data stores a five-digit value into data set 1..4.
// R21: Delete removes the stored message named by five digits.
// R22: Program stores up to 223 characters only when end-of-text terminates.
// R23: End-of-text terminates program and display-text commands.
// R24: Unknown letters or out-of-range operands are dropped, settings unchanged.
`include "ascii_cmd_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module cmd_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_i,     // Clock
  input  wire logic         resetn_i,  // Sync reset
  input  wire logic [W-1:0] in_data_i, // Write data
  input  wire logic         in_valid_i,// Write request
  output logic              in_ready_o,// Not full
  output logic [W-1:0]      out_data_o,// Head word
  output logic              out_valid_o,// Not empty
  input  wire logic         out_ready_i // Drain
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          wr;
  logic          rd;
  logic [AW:0]   nxt_cnt;

  assign wr = in_valid_i & in_ready_o;
  assign rd = out_valid_o & out_ready_i;
  assign nxt_cnt = cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
  assign out_data_o = mem[rp_ff];
  assign out_valid_o = (cnt_ff != '0);

  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem[wp_ff] <= in_data_i;
    end
  end

  // Ready is a flop so the host sees a clean level
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wp_ff      <= '0;
      rp_ff      <= '0;
      cnt_ff     <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wp_ff      <= wp_ff + AW'(wr);
      rp_ff      <= rp_ff + AW'(rd);
      cnt_ff     <= nxt_cnt;
      in_ready_o <= (nxt_cnt != (AW+1)'(D));
    end
  end
endmodule

module ascii_display_command_parser (
  input  wire logic                sys_clk_i,       // 10 MHz clock
  input  wire logic                resetn_i,        // Sync reset, low
  input  wire logic                ascii_port_i,    // 0 computer, 1 controller
  input  wire logic [7:0]          cp_data_i,       // Computer port byte
  input  wire logic                cp_valid_i,      // Computer port strobe
  input  wire logic [7:0]          pl_data_i,       // Controller port byte
  input  wire logic                pl_valid_i,      // Controller port strobe
  output logic                     rx_ready_o,      // Room in FIFO
  input  wire logic [6:0]          group_number_i,  // Own group
  input  wire logic [13:0]         unit_number_i,   // Own unit
  input  wire logic                text_ready_i,    // Display takes char
  output logic                     text_valid_o,    // Char to show
  output logic [7:0]               text_char_o,     // Char code
  output logic [2:0]               text_row_o,      // Char row
  output logic [5:0]               text_col_o,      // Char column
  output logic [2:0]               cursor_row_o,    // Cursor row
  output logic [5:0]               cursor_col_o,    // Cursor column
  output logic                     selected_o,      // Unit selected
  output logic                     queue_en_o,      // Queue enabled
  output logic                     center_o,        // Centering
  output logic                     new_line_o,      // CR to next line
  output logic                     wrap_o,          // Wrap at line end
  output logic [6:0]               scroll_rate_o,   // Tenths
  output logic [6:0]               blink_on_o,      // Tenths
  output logic [6:0]               blink_off_o,     // Tenths
  output logic                     clear_disp_o,    // Clear pulse
  output logic                     clear_queue_o,   // Dequeue pulse
  output logic                     clear_all_o,     // Empty whole queue
  output logic                     trigger_o,       // Show stored msg
  output logic                     delete_o,        // Delete stored msg
  output ascii_cmd_pkg::num_t      msg_num_o,       // Message number
  output logic                     var_load_o,      // Data set pulse
  output logic [1:0]               var_set_o,       // Set 0..3
  output ascii_cmd_pkg::num_t      var_val_o,       // Set value
  output logic                     prog_store_o,    // Message done
  output ascii_cmd_pkg::num_t      prog_num_o,      // Its number
  output logic [7:0]               prog_len_o,      // Its length
  input  wire logic [7:0]          prog_rd_addr_i,  // Buffer read
  output logic [7:0]               prog_rd_data_o   // Buffer data
);
  import ascii_cmd_pkg::*;

  function automatic num_t dec_step(input num_t a, input logic [3:0] d);
    return num_t'(a * 17'h0_000A + {13'h0, d});
  endfunction

  function automatic logic rng(input num_t v, input num_t mx);
    return (v >= 17'h0_0001) && (v <= mx);
  endfunction

  function automatic logic [2:0] nxt_row(input logic [2:0] r);
    return (r == `ROWS) ? 3'h1 : r + 3'h1;
  endfunction

  // Operand count per letter; case matters
  function automatic logic [2:0] opnd_len(input logic [7:0] c);
    unique case (c)
      `CMD_SEL, `CMD_VAR:                       return 3'h6; // R06
      `CMD_CLRQ, `CMD_TRIG, `CMD_DEL, `CMD_PROG: return 3'h5;
      `CMD_BLNK, `CMD_CUR:                      return 3'h4;
      `CMD_SCRL:                                return 3'h2;
      `CMD_QEN, `CMD_CTR, `CMD_RST, `CMD_NL, `CMD_WRAP: return 3'h1;
      `CMD_SHOW:                                return 3'h0;
      default:                                  return `LEN_BAD;
    endcase
  endfunction

  function automatic logic [2:0] opnd_split(input logic [7:0] c);
    unique case (c)
      `CMD_SEL, `CMD_BLNK, `CMD_CUR: return 3'h2;
      `CMD_VAR:                      return 3'h1;
      default:                       return 3'h0;
    endcase
  endfunction

  // ****************************************
  // Input path
  // ****************************************
  logic [7:0] f_data;
  logic       f_valid;
  logic       f_ready;
  logic       fire;

  assign f_ready = !(text_valid_o && !text_ready_i);
  assign fire = f_valid && f_ready;

  cmd_fifo #(.W(`FIFO_W), .D(`FIFO_D)) u_fifo (
    .clk_i       (sys_clk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (ascii_port_i ? pl_data_i : cp_data_i),  // R01
    .in_valid_i  (ascii_port_i ? pl_valid_i : cp_valid_i),
    .in_ready_o  (rx_ready_o),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready)
  );

  // ****************************************
  // Parser
  // ****************************************
  parse_st_t   st_ff;
  logic [7:0]  cmd_ff;
  logic [2:0]  idx_ff;
  logic [2:0]  len_ff;
  logic [2:0]  spl_ff;
  num_t        hi_ff;
  num_t        lo_ff;
  logic        in_txt_ff;
  logic        prog_ff;
  logic        is_hat;
  logic        is_dig;
  logic        is_txt;
  logic [3:0]  dig;
  num_t        nxt_hi;
  num_t        nxt_lo;
  logic        last;
  logic        exec;
  logic        a_match;

  assign is_hat = (f_data == `CH_HAT);
  assign is_dig = (f_data >= `CH_0) && (f_data <= `CH_9);
  assign dig = f_data[3:0];
  assign is_txt = !is_hat && (f_data == `CH_CR || (f_data >= `CH_SP && f_data <= `CH_TILDE)); // R02
  assign nxt_hi = (idx_ff < spl_ff) ? dec_step(hi_ff, dig) : hi_ff;
  assign nxt_lo = (idx_ff == spl_ff) ? {13'h0, dig} : dec_step(lo_ff, dig);
  assign last = (idx_ff + 3'h1 == len_ff);
  assign exec = fire && st_ff == ST_OPER && is_dig && last; // R03
  assign a_match = (hi_ff == '0 && nxt_lo == '0) ||
                   (hi_ff == {10'h0, group_number_i} &&
                    (nxt_lo == '0 || nxt_lo == {3'h0, unit_number_i})); // R09

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st_ff     <= ST_IDLE;
      cmd_ff    <= 8'h00;
      idx_ff    <= 3'h0;
      len_ff    <= 3'h0;
      spl_ff    <= 3'h0;
      hi_ff     <= '0;
      lo_ff     <= '0;
      in_txt_ff <= 1'b0;
      prog_ff   <= 1'b0;
    end else if (fire) begin
      if (is_hat) begin
        st_ff <= ST_HAT; // R04
      end else begin
        unique case (st_ff)
          ST_IDLE: begin
          end
          ST_HAT: begin
            if (!selected_o && f_data != `CMD_SEL) begin
              st_ff     <= ST_IDLE; // R05
              in_txt_ff <= 1'b0;
            end else if (in_txt_ff && f_data == `CMD_ATTR) begin
              st_ff  <= ST_ATTR; // R04
              idx_ff <= 3'h0;
            end else if (in_txt_ff && f_data == `CMD_EOT) begin
              st_ff     <= ST_IDLE; // R23
              in_txt_ff <= 1'b0;
            end else begin
              in_txt_ff <= 1'b0;
              cmd_ff    <= f_data;
              idx_ff    <= 3'h0;
              hi_ff     <= '0;
              lo_ff     <= '0;
              len_ff    <= opnd_len(f_data);
              spl_ff    <= opnd_split(f_data);
              if (opnd_len(f_data) == `LEN_BAD) begin
                st_ff <= ST_IDLE; // R24
              end else if (f_data == `CMD_SHOW) begin
                st_ff     <= ST_TEXT;
                in_txt_ff <= 1'b1;
                prog_ff   <= 1'b0;
              end else begin
                st_ff <= ST_OPER;
              end
            end
          end
          ST_OPER: begin
            if (!is_dig) begin
              st_ff <= ST_IDLE; // R24
            end else begin
              idx_ff <= idx_ff + 3'h1;
              hi_ff  <= nxt_hi;
              lo_ff  <= nxt_lo;
              if (last && cmd_ff == `CMD_PROG) begin
                st_ff     <= ST_TEXT;
                in_txt_ff <= 1'b1;
                prog_ff   <= 1'b1;
              end else if (last) begin
                st_ff <= ST_IDLE;
              end
            end
          end
          ST_TEXT: begin
          end
          ST_ATTR: begin
            // Attribute codes are consumed, not acted on
            idx_ff <= idx_ff + 3'h1;
            if (!is_dig || idx_ff == 3'h1) begin
              st_ff <= ST_TEXT;
            end
          end
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Settings
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      selected_o    <= 1'b0;
      queue_en_o    <= 1'b0; // R11
      center_o      <= 1'b0;
      new_line_o    <= 1'b1;
      wrap_o        <= 1'b1;
      scroll_rate_o <= `DEF_SCROLL;
      blink_on_o    <= `DEF_BLINK;
      blink_off_o   <= `DEF_BLINK;
    end else if (exec) begin
      unique case (cmd_ff)
        `CMD_SEL:  selected_o <= a_match; // R08
        `CMD_QEN:  if (nxt_lo < 17'h0_0002) queue_en_o <= (nxt_lo == '0); // R11
        `CMD_CTR:  if (nxt_lo < 17'h0_0002) center_o <= nxt_lo[0]; // R12
        `CMD_NL:   if (nxt_lo < 17'h0_0002) new_line_o <= nxt_lo[0]; // R17
        `CMD_WRAP: if (nxt_lo < 17'h0_0002) wrap_o <= nxt_lo[0]; // R18
        `CMD_SCRL: if (rng(nxt_lo, `RATE_MAX)) scroll_rate_o <= nxt_lo[6:0]; // R14
        `CMD_BLNK: begin
          if (rng(hi_ff, `RATE_MAX) && rng(nxt_lo, `RATE_MAX)) begin
            blink_on_o  <= hi_ff[6:0]; // R15
            blink_off_o <= nxt_lo[6:0];
          end
        end
        `CMD_RST: begin
          if (nxt_lo == 17'h0_0001) begin
            queue_en_o    <= 1'b0; // R13
            center_o      <= 1'b0;
            new_line_o    <= 1'b1;
            wrap_o        <= 1'b1;
            scroll_rate_o <= `DEF_SCROLL;
            blink_on_o    <= `DEF_BLINK;
            blink_off_o   <= `DEF_BLINK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Command pulses
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      clear_disp_o  <= 1'b0;
      clear_queue_o <= 1'b0;
      clear_all_o   <= 1'b0;
      trigger_o     <= 1'b0;
      delete_o      <= 1'b0;
      var_load_o    <= 1'b0;
      msg_num_o     <= '0;
      var_set_o     <= 2'h0;
      var_val_o     <= '0;
    end else begin
      clear_disp_o  <= exec && cmd_ff == `CMD_RST && nxt_lo < 17'h0_0003; // R13
      clear_queue_o <= exec && cmd_ff == `CMD_CLRQ; // R10
      clear_all_o   <= exec && cmd_ff == `CMD_CLRQ && nxt_lo == `Q_ALL; // R10
      trigger_o     <= exec && cmd_ff == `CMD_TRIG; // R19
      delete_o      <= exec && cmd_ff == `CMD_DEL; // R21
      var_load_o    <= exec && cmd_ff == `CMD_VAR && rng(hi_ff, `N_SETS); // R20
      if (exec && (cmd_ff == `CMD_CLRQ || cmd_ff == `CMD_TRIG || cmd_ff == `CMD_DEL)) begin
        msg_num_o <= nxt_lo;
      end
      if (exec && cmd_ff == `CMD_VAR) begin
        var_set_o <= 2'(hi_ff - 17'h0_0001);
        var_val_o <= nxt_lo;
      end
    end
  end

  // ****************************************
  // Cursor and text out
  // ****************************************
  logic show;

  // Text is shown when idle-selected or inside display-text
  // Program flag outlives its upload, so it only gates text state
  assign show = fire && selected_o && is_txt && (st_ff == ST_IDLE || (st_ff == ST_TEXT && !prog_ff)); // R05

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cursor_row_o <= 3'h1;
      cursor_col_o <= 6'h01;
      text_valid_o <= 1'b0;
      text_char_o  <= 8'h00;
      text_row_o   <= 3'h1;
      text_col_o   <= 6'h01;
    end else begin
      if (text_ready_i) begin
        text_valid_o <= 1'b0;
      end
      if (exec && cmd_ff == `CMD_RST && nxt_lo < 17'h0_0002) begin
        cursor_row_o <= 3'h1; // R13
        cursor_col_o <= 6'h01;
      end else if (exec && cmd_ff == `CMD_CUR) begin
        if (rng(hi_ff, {14'h0, `ROWS}) && rng(nxt_lo, {11'h0, `COLS})) begin
          cursor_row_o <= hi_ff[2:0]; // R16
          cursor_col_o <= nxt_lo[5:0];
        end
      end else if (show && f_data == `CH_CR) begin
        cursor_col_o <= 6'h01; // R17
        if (new_line_o) begin
          cursor_row_o <= nxt_row(cursor_row_o);
        end
      end else if (show) begin
        text_valid_o <= 1'b1;
        text_char_o  <= f_data;
        text_row_o   <= cursor_row_o;
        text_col_o   <= cursor_col_o;
        if (cursor_col_o != `COLS) begin
          cursor_col_o <= cursor_col_o + 6'h01;
        end else if (wrap_o) begin
          cursor_col_o <= 6'h01; // R18
          cursor_row_o <= nxt_row(cursor_row_o);
        end
      end
    end
  end

  // ****************************************
  // Program buffer
  // ****************************************
  // Held here until end-of-text, so a broken upload never reaches the store
  logic [7:0] pbuf [0:222];
  logic [7:0] plen_ff;
  logic       ovf_ff;
  logic       stor;
  logic       commit;

  assign stor = fire && is_txt && prog_ff && st_ff == ST_TEXT;
  assign commit = fire && st_ff == ST_HAT && in_txt_ff && prog_ff && f_data == `CMD_EOT;

  always_ff @(posedge sys_clk_i) begin
    if (stor && plen_ff < `MSG_MAX) begin
      pbuf[plen_ff] <= f_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      plen_ff        <= 8'h00;
      ovf_ff         <= 1'b0;
      prog_store_o   <= 1'b0;
      prog_num_o     <= '0;
      prog_len_o     <= 8'h00;
      prog_rd_data_o <= 8'h00;
    end else begin
      prog_store_o   <= commit && !ovf_ff; // R22
      prog_rd_data_o <= (prog_rd_addr_i < `MSG_MAX) ? pbuf[prog_rd_addr_i] : 8'h00;
      if (exec && cmd_ff == `CMD_PROG) begin
        plen_ff <= 8'h00;
        ovf_ff  <= 1'b0;
        prog_num_o <= nxt_lo;
      end else if (stor) begin
        if (plen_ff == `MSG_MAX) begin
          ovf_ff <= 1'b1; // R22
        end else begin
          plen_ff <= plen_ff + 8'h01;
        end
      end
      if (commit && !ovf_ff) begin
        prog_len_o <= plen_ff; // R23
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_sel_exec;
    exec && cmd_ff == `CMD_SEL;
  endsequence

  a_sel_match: assert property (s_sel_exec |=> selected_o == $past(a_match)) // R09
    else $error("select result wrong");
  a_unsel_quiet: assert property (fire && !selected_o |=> !text_valid_o && !trigger_o && !delete_o) // R05
    else $error("unselected unit acted");
  a_hat_hidden: assert property (fire && is_hat |=> st_ff == ST_HAT && !text_valid_o) // R04
    else $error("circumflex mishandled");
  a_queue_enable: assert property ($rose(queue_en_o) |-> $past(exec && cmd_ff == `CMD_QEN && nxt_lo == '0)) // R11
    else $error("queue enabled without command");
  a_clear_all: assert property (clear_all_o |-> clear_queue_o && msg_num_o == `Q_ALL) // R10
    else $error("clear-all mismatch");
  a_trig_full: assert property (trigger_o |-> $past(st_ff == ST_OPER && idx_ff == 3'h4)) // R03
    else $error("trigger before five digits");
  a_cursor_range: assert property (cursor_row_o >= 3'h1 && cursor_row_o <= `ROWS && cursor_col_o <= `COLS) // R16
    else $error("cursor out of range");
  a_wrap_stay: assert property (show && !is_hat && f_data != `CH_CR && cursor_col_o == `COLS && !wrap_o
                                |=> cursor_col_o == `COLS && $stable(cursor_row_o)) // R18
    else $error("cursor moved with wrap off");
  a_prog_len: assert property (prog_store_o |-> prog_len_o <= `MSG_MAX && $past(commit)) // R22
    else $error("bad program store");
endmodule
`default_nettype wire

/* File: test/host_model.sv */
// Host model that streams ASCII command bytes
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       ready_i, // Room in receive FIFO
  output logic [7:0]      data_o,  // Byte
  output logic            valid_o  // Byte strobe
);
  initial begin
    data_o  = 8'h00;
    valid_o = 1'b0;
  end
  // Called at a falling edge; bytes go back to back
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      data_o  = s[i];
      valid_o = 1'b1;
      while (ready_i !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
    end
    valid_o = 1'b0;
    data_o  = ~data_o;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_ascii_display_command_parser.sv */
// Self-checking bench for the ASCII command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_ascii_display_command_parser;
  import ascii_cmd_pkg::*;
  logic       sys_clk = 1'b0, resetn = 1'b0, text_ready = 1'b1, cp_valid, rx_ready, text_valid;
  logic [7:0] cp_data, text_char, prog_len, prog_rd_data, prog_rd_addr = 8'h00;
  logic [2:0] text_row, cursor_row;
  logic [5:0] text_col, cursor_col;
  logic       selected, queue_en, center, new_line, wrap;
  logic [6:0] scroll, blink_on, blink_off, pul;
  logic [1:0] var_set;
  num_t       msg_num, var_val, prog_num;
  logic [7:0] txt[$];
  logic [8:0] pos0;
  int         cnt[7], fails = 0, total_checks = 0, cycles = 0;
  string      s;
  string      sa[7] = '{"^A030124", "^A030125", "^A030000", "^A040000", "^A000000", "^A000124", "^A030124"};
  bit         se[7] = '{1, 0, 1, 0, 1, 0, 1};

  // Unselected controller port carries junk the whole run
  ascii_display_command_parser ascii_display_command_parser_inst (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .ascii_port_i(1'b0), .cp_data_i(cp_data), .cp_valid_i(cp_valid),
    .pl_data_i(8'h51), .pl_valid_i(1'b1), .rx_ready_o(rx_ready), .group_number_i(7'h03),
    .unit_number_i(14'h007C), .text_ready_i(text_ready), .text_valid_o(text_valid), .text_char_o(text_char),
    .text_row_o(text_row), .text_col_o(text_col), .cursor_row_o(cursor_row), .cursor_col_o(cursor_col),
    .selected_o(selected), .queue_en_o(queue_en), .center_o(center), .new_line_o(new_line), .wrap_o(wrap),
    .scroll_rate_o(scroll), .blink_on_o(blink_on), .blink_off_o(blink_off), .clear_disp_o(pul[0]),
    .clear_queue_o(pul[1]), .clear_all_o(pul[2]), .trigger_o(pul[3]), .delete_o(pul[4]), .msg_num_o(msg_num),
    .var_load_o(pul[5]), .var_set_o(var_set), .var_val_o(var_val), .prog_store_o(pul[6]),
    .prog_num_o(prog_num), .prog_len_o(prog_len), .prog_rd_addr_i(prog_rd_addr), .prog_rd_data_o(prog_rd_data)
  );
  host_model host_model_inst (.clk_i(sys_clk), .ready_i(rx_ready), .data_o(cp_data), .valid_o(cp_valid));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    for (int k = 0; k < 7; k++) cnt[k] <= cnt[k] + pul[k];
    if (text_valid === 1'b1 && text_ready === 1'b1) begin
      if (txt.size() == 0) pos0 <= {text_row, text_col};
      txt.push_back(text_char);
    end
    if (cycles == 8000) begin
      fails++;
      complete_run();
    end
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic run(input string c);
    txt.delete();
    for (int k = 0; k < 7; k++) cnt[k] = 0;
    host_model_inst.send(c);
    repeat (8) @(negedge sys_clk);
  endtask

  task automatic tchk(input string e);
    chk("text count", e.len(), txt.size());
    foreach (txt[i]) chk("text char", (i < e.len()) ? e[i] : 8'h00, txt[i]);
  endtask

  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk("modes", 5'h03, {selected, queue_en, center, new_line, wrap});
    chk("rates", {7'h0A, 7'h05, 7'h05}, {scroll, blink_on, blink_off});
    run("Hi^C1"); tchk(""); chk("center", 0, center);
    for (int i = 0; i < 7; i++) begin
      run(sa[i]); chk("selected", se[i], selected);
    end
    run("A\007^F05b~"); tchk("Ab~"); chk("scroll", 7'h05, scroll);
    chk("pos", {3'h1, 6'h01}, pos0); chk("cursor", {3'h1, 6'h04}, {cursor_row, cursor_col});
    run("^c0"); chk("queue_en", 1, queue_en);
    run("^c1^C1"); chk("queue_center", 2'h1, {queue_en, center});
    run("^C0"); chk("center", 0, center);
    run("^F99"); chk("scroll", 7'h63, scroll);
    run("^F00"); chk("scroll", 7'h63, scroll);
    run("^F9^F01"); chk("scroll", 7'h01, scroll);
    run("^G0199"); chk("blink", {7'h01, 7'h63}, {blink_on, blink_off});
    run("^H0440"); chk("cursor", {3'h4, 6'h28}, {cursor_row, cursor_col});
    run("^H0541"); chk("cursor", {3'h4, 6'h28}, {cursor_row, cursor_col});
    run("^H0140xy"); chk("cursor", {3'h2, 6'h02}, {cursor_row, cursor_col});
    run("^J0^H0140xy"); chk("cursor", {3'h1, 6'h28}, {cursor_row, cursor_col});
    run("^I0^H0305\015"); chk("cursor", {3'h3, 6'h01}, {cursor_row, cursor_col});
    run("^I1\015"); chk("cursor", {3'h4, 6'h01}, {cursor_row, cursor_col});
    run("^E2"); chk("clear_cursor", {1'b1, 3'h4, 6'h01}, {cnt[0][0], cursor_row, cursor_col});
    run("^E0"); chk("cursor", {3'h1, 6'h01}, {cursor_row, cursor_col});
    run("^F22^E1"); chk("restore", {1'b1, 7'h0A}, {wrap, scroll});
    run("^E3"); chk("clear", 0, cnt[0]);
    run("^K00439"); chk("trigger", {1'b1, 17'h0_01B7}, {cnt[3][0], msg_num});
    run("^N00007"); chk("delete", {1'b1, 17'h0_0007}, {cnt[4][0], msg_num});
    run("^b00012"); chk("dequeue", {2'h1, 17'h0_000C}, {cnt[2][0], cnt[1][0], msg_num});
    run("^b65535"); chk("clear_all", 1, cnt[2]);
    run("^M212345"); chk("var", {3'h5, 17'h0_3039}, {cnt[5][0], var_set, var_val});
    run("^M512345"); chk("var", 0, cnt[5]);
    run("^O00228ab\015c^Z"); chk("prog", {1'b1, 17'h0_00E4, 8'h04}, {cnt[6][0], prog_num, prog_len});
    repeat (2) @(negedge sys_clk);
    chk("buffer", 8'h61, prog_rd_data);
    prog_rd_addr = 8'hDF;
    repeat (2) @(negedge sys_clk);
    chk("buffer", 8'h00, prog_rd_data);
    run("^O00005ab^F10"); chk("prog", 0, cnt[6]);
    s = "";
    repeat (223) s = {s, "k"};
    run({"^O00006", s, "^Z"}); chk("prog_len", {1'b1, 8'hDF}, {cnt[6][0], prog_len});
    run({"^O00006", s, "k^Z"}); chk("prog", 0, cnt[6]);
    // Display stalls so the receive FIFO must fill and refuse
    text_ready = 1'b0;
    txt.delete();
    s = "abcdefghijklmnopqrstuvwx";
    fork
      host_model_inst.send(s);
      begin
        repeat (40) @(negedge sys_clk);
        chk("rx_ready", 0, rx_ready);
        text_ready = 1'b1;
      end
    join
    // A full FIFO still has to drain through the display
    repeat (24) @(negedge sys_clk);
    tchk(s);
    complete_run();
  end
endmodule
`default_nettype wire
